/* File: src/cmc_pkg.sv */
package cmc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] MSG_CTRL_B_ADDR    = 8'h0B;
  localparam logic [7:0] CHAN_STAT_A_ADDR   = 8'h0C;
  localparam logic [7:0] MSG_CTRL_B_RESET   = 8'h00;
  localparam logic [7:0] CHAN_STAT_A_RESET  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  // ==========================================================================
  // message_control_b fields
  localparam int TX_DELETE_ON_ERROR_BIT    = 7;
  localparam int HOST_CHECKSUM_VERIFY_BIT  = 6;
  localparam int CHECKSUM_INSERT_BIT       = 5;
  localparam int TX_SIZE_CHECK_EN_BIT      = 4;
  localparam int TX_KEEP_MESSAGE_BIT       = 3;
  localparam int RX_CHECKSUM_CHECK_EN_BIT  = 2;
  localparam int RX_WHOLE_MSG_READY_EN_BIT = 1;
  localparam int LINE_POLARITY_INVERT_BIT  = 0;

  // ==========================================================================
  // channel_status_a fields
  localparam int CHANNEL_SOFT_RESET_BIT    = 7;
  localparam int FRAMER_ENABLE_BIT         = 6;
  localparam int SUPPLY_LIMIT_LATCHED_BIT  = 5;
  localparam int SUPPLY_UV_LATCHED_BIT     = 4;
  localparam int LINE_FAULT_LATCHED_BIT    = 3;
  localparam int SUPPLY_LIMIT_NOW_BIT      = 2;
  localparam int SUPPLY_UV_NOW_BIT         = 1;
  localparam int LINE_FAULT_NOW_BIT        = 0;

  // ==========================================================================
  // Message checksum
  localparam logic [7:0] CHECKSUM_SEED     = 8'h52;
  localparam logic [7:0] CHECK_TYPE_INDEX  = 8'h01;
  localparam logic [7:0] CHECKSUM_MASK     = 8'hC0;
endpackage

/* File: src/cmc_cor_flag.sv */
`timescale 1ns/10ps
module cmc_cor_flag (
  input  wire logic clock,   // System clock
  input  wire logic srst,    // Synchronous reset
  input  wire logic kill,    // Channel soft reset, wins over all
  input  wire logic level,   // Real-time condition
  input  wire logic clr,     // Status register read
  output logic      latched  // Clear-on-read copy
);
  logic prev;
  logic next_prev;
  logic next_latched;

  // ==========================================================================
  // Rising edge latch, set wins over read
  always_comb begin
    next_prev    = level;
    next_latched = latched;
    if (clr) begin
      next_latched = 1'b0;
    end
    if (level && !prev) begin
      next_latched = 1'b1;
    end
    if (kill) begin
      next_latched = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prev    <= 1'b0;
      latched <= 1'b0;
    end else begin
      prev    <= next_prev;
      latched <= next_latched;
    end
  end
endmodule

/* File: src/cmc_chk6.sv */
`timescale 1ns/10ps
module cmc_chk6 (
  input  wire logic       clock,     // System clock
  input  wire logic       srst,      // Synchronous reset
  input  wire logic       restart,   // Start a new message
  input  wire logic       in_valid,  // Byte strobe
  input  wire logic [7:0] in_data,   // Byte
  input  wire logic       mask_low,  // Zero the six checksum bits of this byte
  output logic      [5:0] csum       // Compressed checksum of bytes so far
);
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic [7:0] term;

  // ==========================================================================
  // XOR accumulation from the seed
  always_comb begin
    term     = mask_low ? (in_data & cmc_pkg::CHECKSUM_MASK) : in_data;
    next_acc = acc;
    if (restart) begin
      next_acc = cmc_pkg::CHECKSUM_SEED;
    end else if (in_valid) begin
      next_acc = acc ^ term;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      acc <= cmc_pkg::CHECKSUM_SEED;
    end else begin
      acc <= next_acc;
    end
  end

  // Fold eight bits to six
  assign csum = {acc[7] ^ acc[5] ^ acc[3] ^ acc[1], acc[6] ^ acc[4] ^ acc[2] ^ acc[0],
                 acc[7] ^ acc[6], acc[5] ^ acc[4], acc[3] ^ acc[2], acc[1] ^ acc[0]};
endmodule

/* File: src/cmc_channel_regs.sv */
// Behaviour
// - Bad fully loaded message, delete enabled: clear transmit queue B.
// - Host checksum verify compares host check bits to own value, flags mismatch.
// - Checksum insert replaces the six check bits with the computed checksum.
// - Size check compares queued byte count with length field; error pulses.
// - Message still loading when sending begins is never auto deleted.
// - Keep bit holds the queue after sending; otherwise queue is emptied.
// - Receive checksum check flags a failed device message checksum.
// - Ready event after whole good message, or at first word when clear.
// - Polarity bit clear inverts line to tx/rx pins; set follows line.
// - Channel A soft reset clears framer enable, the three latched bits and both A queues, self clears; the real-time bits are kept.
// - Framer enable selects internal handler over external UART pins.
// - Supply limit latch sets on rising edge, clears on status read.
// - Undervoltage latch sets on rising edge, clears on status read.
// - Line fault latch sets on rising edge, clears on status read.
// - Supply limit flag after blanking time, clears on leaving autoretry.
// - Undervoltage flag sets on falling threshold, clears on rising threshold.
// - Line fault flag follows the driver fault in real time.
// - Receive and transmit checksum errors clear on error register read.
`timescale 1ns/10ps
module cmc_channel_regs #(
  parameter int BLANK_W = 16  // Width of blanking count
) (
  input  wire logic               clock,                // 50 MHz system clock
  input  wire logic               srst,                 // Synchronous reset
  // Register port from the serial front end
  input  wire logic [7:0]         reg_addr,             // Register address
  input  wire logic               reg_wr,               // Write strobe
  input  wire logic               reg_rd,               // Read strobe
  input  wire logic [7:0]         reg_wdata,            // Write data
  output logic      [7:0]         reg_rdata,            // Read data, next cycle
  // Channel B transmit side
  input  wire logic               tx_load_valid_b,      // Byte written to queue
  input  wire logic [7:0]         tx_load_data_b,       // That byte
  input  wire logic               tx_msg_loaded_b,      // Message fully loaded
  input  wire logic [7:0]         tx_length_field,      // Byte count of message
  input  wire logic               tx_send_start_b,      // Sending begins
  input  wire logic               tx_send_done_b,       // Sending finished
  input  wire logic               transmit_queue_clear_b, // Host queue clear
  input  wire logic               line_error_read_b,    // Error register read
  output logic                    tx_queue_reset_b,     // Empty transmit queue
  output logic      [7:0]         check_type_octet,     // Octet to send
  output logic                    tx_error_irq_b,       // Transmit error pulse
  output logic                    tx_checksum_err_b,    // Sticky flag
  // Channel B receive side
  input  wire logic               rx_word_valid_b,      // Word into queue
  input  wire logic [7:0]         rx_word_data_b,       // That word
  input  wire logic               rx_word_last_b,       // Last word of response
  input  wire logic               rx_frame_bad_b,       // Other receive error
  output logic                    rx_checksum_err_b,    // Sticky flag
  output logic                    rx_data_ready_irq_b,  // Ready pulse
  // Channel B line polarity
  input  wire logic               line_pin_b,           // Line receiver level
  input  wire logic               tx_pin_b,             // Transmit data
  output logic                    rx_pin_b,             // Receive data
  output logic                    line_drive_b,         // Line driver level
  // Channel A pins
  input  wire logic               framer_tx_a,          // Internal framer data
  input  wire logic               framer_txen_a,        // Internal framer enable
  input  wire logic               tx_pin_a,             // External UART data
  input  wire logic               tx_drive_enable_pin_a, // External UART enable
  input  wire logic               line_rx_a,            // Line receiver level
  output logic                    rx_pin_a,             // To external UART
  output logic                    framer_rx_a,          // To internal framer
  output logic                    line_drive_a,         // Line driver level
  output logic                    line_drive_en_a,      // Line driver enable
  output logic                    framer_enable_a,      // Handler and queues on
  output logic                    queue_reset_a,        // Empty both A queues
  // Channel A supply and fault sources
  input  wire logic               supply_overcurrent_a, // Raw over-current
  input  wire logic               supply_autoretry_a,   // In autoretry limiting
  input  wire logic [BLANK_W-1:0] blanking_cycles_a,    // Programmed blanking
  input  wire logic               supply_fall_a,        // Below falling threshold
  input  wire logic               supply_rise_a,        // Above rising threshold
  input  wire logic               driver_fault_a,       // Line driver fault
  output logic                    status_irq            // Any latched flag
);
  if (BLANK_W < 1 || BLANK_W > 32) begin : g_bad_width
    $error("BLANK_W out of range");
  end

  // ==========================================================================
  // Register file
  logic [7:0] msg_ctrl;
  logic [7:0] next_msg_ctrl;
  logic       soft_rst_pend;
  logic       next_soft_rst_pend;
  logic       next_framer_enable_a;
  logic [7:0] next_reg_rdata;
  logic       stat_read;
  logic       supply_limit_now_a;
  logic       supply_undervolt_now_a;
  logic       line_fault_now_a;
  logic       supply_limit_latched_a;
  logic       supply_undervolt_latched_a;
  logic       line_fault_latched_a;
  logic [7:0] chan_stat;

  assign stat_read = reg_rd && (reg_addr == cmc_pkg::CHAN_STAT_A_ADDR);

  always_comb begin
    chan_stat = cmc_pkg::CHAN_STAT_A_RESET;
    chan_stat[cmc_pkg::CHANNEL_SOFT_RESET_BIT]   = soft_rst_pend;
    chan_stat[cmc_pkg::FRAMER_ENABLE_BIT]        = framer_enable_a;
    chan_stat[cmc_pkg::SUPPLY_LIMIT_LATCHED_BIT] = supply_limit_latched_a;
    chan_stat[cmc_pkg::SUPPLY_UV_LATCHED_BIT]    = supply_undervolt_latched_a;
    chan_stat[cmc_pkg::LINE_FAULT_LATCHED_BIT]   = line_fault_latched_a;
    chan_stat[cmc_pkg::SUPPLY_LIMIT_NOW_BIT]     = supply_limit_now_a;
    chan_stat[cmc_pkg::SUPPLY_UV_NOW_BIT]        = supply_undervolt_now_a;
    chan_stat[cmc_pkg::LINE_FAULT_NOW_BIT]       = line_fault_now_a;
  end

  always_comb begin
    next_msg_ctrl        = msg_ctrl;
    next_framer_enable_a = framer_enable_a;
    next_soft_rst_pend   = 1'b0;
    next_reg_rdata       = reg_rdata;
    if (soft_rst_pend) begin
      next_framer_enable_a = 1'b0;
    end else if (reg_wr && reg_addr == cmc_pkg::CHAN_STAT_A_ADDR) begin
      next_framer_enable_a = reg_wdata[cmc_pkg::FRAMER_ENABLE_BIT];
      next_soft_rst_pend   = reg_wdata[cmc_pkg::CHANNEL_SOFT_RESET_BIT];
    end
    if (reg_wr && reg_addr == cmc_pkg::MSG_CTRL_B_ADDR) begin
      next_msg_ctrl = reg_wdata;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        cmc_pkg::MSG_CTRL_B_ADDR:  next_reg_rdata = msg_ctrl;
        cmc_pkg::CHAN_STAT_A_ADDR: next_reg_rdata = chan_stat;
        default:                   next_reg_rdata = cmc_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      msg_ctrl        <= cmc_pkg::MSG_CTRL_B_RESET;
      framer_enable_a <= 1'b0;
      soft_rst_pend   <= 1'b0;
      reg_rdata       <= cmc_pkg::UNMAPPED_READ;
    end else begin
      msg_ctrl        <= next_msg_ctrl;
      framer_enable_a <= next_framer_enable_a;
      soft_rst_pend   <= next_soft_rst_pend;
      reg_rdata       <= next_reg_rdata;
    end
  end

  assign queue_reset_a = soft_rst_pend;

  // ==========================================================================
  // Channel A real-time conditions
  logic [BLANK_W-1:0] blank_cnt;
  logic [BLANK_W-1:0] next_blank_cnt;
  logic               next_limit_now;
  logic               next_uv_now;

  always_comb begin
    next_blank_cnt = blank_cnt;
    next_limit_now = supply_limit_now_a;
    next_uv_now    = supply_undervolt_now_a;
    if (!supply_overcurrent_a) begin
      next_blank_cnt = '0;
    end else if (blank_cnt != blanking_cycles_a) begin
      next_blank_cnt = blank_cnt + BLANK_W'(1);
    end else begin
      next_limit_now = 1'b1;
    end
    if (supply_limit_now_a && !supply_autoretry_a) begin
      next_limit_now = 1'b0;
    end
    if (supply_fall_a) begin
      next_uv_now = 1'b1;
    end else if (supply_rise_a) begin
      next_uv_now = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      blank_cnt              <= '0;
      supply_limit_now_a     <= 1'b0;
      supply_undervolt_now_a <= 1'b0;
      line_fault_now_a       <= 1'b0;
    end else begin
      blank_cnt              <= next_blank_cnt;
      supply_limit_now_a     <= next_limit_now;
      supply_undervolt_now_a <= next_uv_now;
      line_fault_now_a       <= driver_fault_a;
    end
  end

  cmc_cor_flag u_limit_flag (
    .clock   (clock),
    .srst    (srst),
    .kill    (soft_rst_pend),
    .level   (supply_limit_now_a),
    .clr     (stat_read),
    .latched (supply_limit_latched_a)
  );

  cmc_cor_flag u_uv_flag (
    .clock   (clock),
    .srst    (srst),
    .kill    (soft_rst_pend),
    .level   (supply_undervolt_now_a),
    .clr     (stat_read),
    .latched (supply_undervolt_latched_a)
  );

  cmc_cor_flag u_fault_flag (
    .clock   (clock),
    .srst    (srst),
    .kill    (soft_rst_pend),
    .level   (line_fault_now_a),
    .clr     (stat_read),
    .latched (line_fault_latched_a)
  );

  assign status_irq = supply_limit_latched_a | supply_undervolt_latched_a
                    | line_fault_latched_a;

  // ==========================================================================
  // Channel A pin routing
  always_ff @(posedge clock) begin
    if (srst) begin
      line_drive_a    <= 1'b0;
      line_drive_en_a <= 1'b0;
      rx_pin_a        <= 1'b1;
      framer_rx_a     <= 1'b1;
    end else begin
      line_drive_a    <= framer_enable_a ? framer_tx_a : tx_pin_a;
      line_drive_en_a <= framer_enable_a ? framer_txen_a : tx_drive_enable_pin_a;
      rx_pin_a        <= framer_enable_a ? 1'b1 : line_rx_a;
      framer_rx_a     <= framer_enable_a ? line_rx_a : 1'b1;
    end
  end

  // ==========================================================================
  // Channel B transmit checks
  logic [7:0] tx_count;
  logic [7:0] next_tx_count;
  logic [7:0] host_ckt;
  logic [7:0] next_host_ckt;
  logic       tx_sending;
  logic       next_tx_sending;
  logic [5:0] tx_csum;
  logic       size_err;
  logic       chk_err;
  logic       delete_now;
  logic       auto_clear;
  logic       queue_clear;
  logic       next_tx_err_irq;
  logic       next_tx_chk_err;
  logic [7:0] next_ckt_out;

  always_comb begin
    size_err   = msg_ctrl[cmc_pkg::TX_SIZE_CHECK_EN_BIT]
               && (tx_count != tx_length_field);
    chk_err    = msg_ctrl[cmc_pkg::HOST_CHECKSUM_VERIFY_BIT]
               && (host_ckt[5:0] != tx_csum);
    delete_now = tx_msg_loaded_b && !tx_sending && (size_err || chk_err)
               && msg_ctrl[cmc_pkg::TX_DELETE_ON_ERROR_BIT];
    auto_clear = tx_send_done_b && !msg_ctrl[cmc_pkg::TX_KEEP_MESSAGE_BIT];
    queue_clear = delete_now || auto_clear || transmit_queue_clear_b;
    next_tx_count   = tx_count;
    next_host_ckt   = host_ckt;
    next_tx_sending = tx_sending;
    next_tx_err_irq = tx_msg_loaded_b && (size_err || chk_err);
    next_tx_chk_err = tx_checksum_err_b;
    if (line_error_read_b) begin
      next_tx_chk_err = 1'b0;
    end
    if (tx_msg_loaded_b && chk_err) begin
      next_tx_chk_err = 1'b1;
    end
    if (tx_send_start_b) begin
      next_tx_sending = 1'b1;
    end else if (tx_send_done_b) begin
      next_tx_sending = 1'b0;
    end
    if (queue_clear) begin
      next_tx_count = '0;
      next_host_ckt = '0;
    end else if (tx_load_valid_b) begin
      next_tx_count = tx_count + 8'h01;
      if (tx_count == cmc_pkg::CHECK_TYPE_INDEX) begin
        next_host_ckt = tx_load_data_b;
      end
    end
    next_ckt_out = msg_ctrl[cmc_pkg::CHECKSUM_INSERT_BIT]
                 ? {host_ckt[7:6], tx_csum} : host_ckt;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_count          <= '0;
      host_ckt          <= '0;
      tx_sending        <= 1'b0;
      tx_error_irq_b    <= 1'b0;
      tx_checksum_err_b <= 1'b0;
      check_type_octet  <= '0;
      tx_queue_reset_b  <= 1'b0;
    end else begin
      tx_count          <= next_tx_count;
      host_ckt          <= next_host_ckt;
      tx_sending        <= next_tx_sending;
      tx_error_irq_b    <= next_tx_err_irq;
      tx_checksum_err_b <= next_tx_chk_err;
      check_type_octet  <= next_ckt_out;
      tx_queue_reset_b  <= queue_clear;
    end
  end

  cmc_chk6 u_tx_chk (
    .clock    (clock),
    .srst     (srst),
    .restart  (queue_clear),
    .in_valid (tx_load_valid_b),
    .in_data  (tx_load_data_b),
    .mask_low (tx_count == cmc_pkg::CHECK_TYPE_INDEX),
    .csum     (tx_csum)
  );

  // ==========================================================================
  // Channel B receive checks
  logic       rx_first;
  logic       next_rx_first;
  logic       rx_bad;
  logic       next_rx_bad;
  logic       rx_last_d;
  logic [5:0] rx_ckt_bits;
  logic [5:0] rx_csum;
  logic       rx_sum_fail;
  logic       next_rx_chk_err;
  logic       next_rx_ready;

  always_comb begin
    rx_sum_fail     = rx_last_d && msg_ctrl[cmc_pkg::RX_CHECKSUM_CHECK_EN_BIT]
                    && (rx_csum != rx_ckt_bits);
    next_rx_first   = rx_first;
    next_rx_bad     = rx_bad || (rx_word_valid_b && rx_frame_bad_b);
    next_rx_chk_err = rx_checksum_err_b;
    next_rx_ready   = 1'b0;
    if (line_error_read_b) begin
      next_rx_chk_err = 1'b0;
    end
    if (rx_sum_fail) begin
      next_rx_chk_err = 1'b1;
    end
    if (rx_word_valid_b) begin
      next_rx_first = 1'b0;
      if (!msg_ctrl[cmc_pkg::RX_WHOLE_MSG_READY_EN_BIT] && rx_first) begin
        next_rx_ready = 1'b1;
      end
    end
    if (rx_last_d) begin
      next_rx_first = 1'b1;
      next_rx_bad   = 1'b0;
      if (msg_ctrl[cmc_pkg::RX_WHOLE_MSG_READY_EN_BIT] && !rx_bad && !rx_sum_fail) begin
        next_rx_ready = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rx_first            <= 1'b1;
      rx_bad              <= 1'b0;
      rx_last_d           <= 1'b0;
      rx_ckt_bits         <= '0;
      rx_checksum_err_b   <= 1'b0;
      rx_data_ready_irq_b <= 1'b0;
    end else begin
      rx_first            <= next_rx_first;
      rx_bad              <= next_rx_bad;
      rx_last_d           <= rx_word_valid_b && rx_word_last_b;
      rx_ckt_bits         <= rx_word_data_b[5:0];
      rx_checksum_err_b   <= next_rx_chk_err;
      rx_data_ready_irq_b <= next_rx_ready;
    end
  end

  cmc_chk6 u_rx_chk (
    .clock    (clock),
    .srst     (srst),
    .restart  (rx_last_d),
    .in_valid (rx_word_valid_b),
    .in_data  (rx_word_data_b),
    .mask_low (rx_word_last_b),
    .csum     (rx_csum)
  );

  // ==========================================================================
  // Channel B line polarity
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_pin_b     <= 1'b0;
      line_drive_b <= 1'b0;
    end else begin
      rx_pin_b     <= msg_ctrl[cmc_pkg::LINE_POLARITY_INVERT_BIT] ? line_pin_b : ~line_pin_b;
      line_drive_b <= msg_ctrl[cmc_pkg::LINE_POLARITY_INVERT_BIT] ? tx_pin_b : ~tx_pin_b;
    end
  end
endmodule

/* File: dv/cmc_asserts.sv */
`timescale 1ns/10ps
module cmc_asserts (
  input wire logic       clock,                  // System clock
  input wire logic       srst,                   // Reset
  input wire logic       reg_rd,                 // Read strobe
  input wire logic [7:0] reg_addr,               // Address
  input wire logic [7:0] reg_rdata,              // Read data
  input wire logic       tx_msg_loaded_b,        // Message loaded
  input wire logic       tx_send_done_b,         // Send done
  input wire logic       transmit_queue_clear_b, // Host clear
  input wire logic       tx_queue_reset_b,       // Queue reset
  input wire logic       tx_error_irq_b,         // Tx error
  input wire logic       line_error_read_b,      // Error read
  input wire logic       tx_checksum_err_b,      // Tx checksum flag
  input wire logic       rx_word_valid_b,        // Rx word
  input wire logic       rx_data_ready_irq_b,    // Rx ready
  input wire logic       queue_reset_a,          // Soft reset pulse
  input wire logic       framer_enable_a,        // Framer on
  input wire logic       driver_fault_a,         // Driver fault
  input wire logic       status_irq              // Latched flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence fault_rise_s;
    $rose(driver_fault_a);
  endsequence
  fault_latch_a: assert property (fault_rise_s |-> ##[1:3] status_irq)
    else $error("fault not latched");
  unmapped_read_a: assert property (reg_rd && reg_addr != 8'h0B && reg_addr != 8'h0C
    |=> reg_rdata == cmc_pkg::UNMAPPED_READ) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  txerr_cause_a: assert property (tx_error_irq_b |-> $past(tx_msg_loaded_b))
    else $error("tx error without load");
  qreset_cause_a: assert property (tx_queue_reset_b |-> $past(tx_msg_loaded_b)
    || $past(tx_send_done_b) || $past(transmit_queue_clear_b))
    else $error("queue reset without cause");
  ready_cause_a: assert property (rx_data_ready_irq_b |-> $past(rx_word_valid_b)
    || $past(rx_word_valid_b, 2)) else $error("ready without word");
  soft_framer_a: assert property (queue_reset_a |=> !framer_enable_a)
    else $error("framer kept over soft reset");
  soft_clear_a: assert property (queue_reset_a |=> !queue_reset_a)
    else $error("soft reset stuck");
  cksum_hold_a: assert property ($fell(tx_checksum_err_b) |-> $past(line_error_read_b))
    else $error("checksum flag dropped");
endmodule
bind cmc_channel_regs cmc_asserts u_chk (.*);

/* File: dv/cmc_host.sv */
`timescale 1ns/10ps
module cmc_host (
  input  wire logic       clock,     // System clock
  input  wire logic [7:0] reg_rdata, // Read data
  output logic      [7:0] reg_addr,  // Address
  output logic            reg_wr,    // Write strobe
  output logic            reg_rd,    // Read strobe
  output logic      [7:0] reg_wdata  // Write data
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

/* File: dv/cmc_channel_regs_tb.sv */
`timescale 1ns/10ps
module cmc_channel_regs_tb;
  logic clock, srst, reg_wr, reg_rd, tx_load_valid_b, tx_msg_loaded_b, tx_send_start_b;
  logic tx_send_done_b, transmit_queue_clear_b, line_error_read_b, tx_queue_reset_b;
  logic tx_error_irq_b, tx_checksum_err_b, rx_word_valid_b, rx_word_last_b, rx_frame_bad_b;
  logic rx_checksum_err_b, rx_data_ready_irq_b, line_pin_b, tx_pin_b, rx_pin_b, line_drive_b;
  logic framer_tx_a, framer_txen_a, tx_pin_a, tx_drive_enable_pin_a, line_rx_a, rx_pin_a;
  logic framer_rx_a, line_drive_a, line_drive_en_a, framer_enable_a, queue_reset_a;
  logic supply_overcurrent_a, supply_autoretry_a, supply_fall_a, supply_rise_a;
  logic driver_fault_a, status_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_load_data_b, tx_length_field;
  logic [7:0] check_type_octet, rx_word_data_b;
  logic [15:0] blanking_cycles_a;
  int error_cnt = 0;
  int n_checks = 0;
  cmc_channel_regs u_dut (.*);
  cmc_host u_host (.*);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk("register", e, d);
  endtask
  task automatic pls(ref logic s);
    s = 1'b1;
    tk(1);
    s = 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic t_regs();
    rd(8'h0B, 8'h00);
    rd(8'h0C, 8'h00);
    u_host.wr(8'h0B, 8'hA5);
    rd(8'h0B, 8'hA5);
    u_host.wr(8'h0C, 8'h3F);
    rd(8'h0C, 8'h00);
    rd(8'h0D, 8'h00);
  endtask
  task automatic t_pol();
    u_host.wr(8'h0B, 8'h00);
    line_pin_b = 1'b1;
    tk(2);
    chk("rx_pin_b", 8'h00, 8'(rx_pin_b));
    chk("line_drive_b", 8'h01, 8'(line_drive_b));
    u_host.wr(8'h0B, 8'h01);
    tk(1);
    chk("rx_pin_b", 8'h01, 8'(rx_pin_b));
    chk("line_drive_b", 8'h00, 8'(line_drive_b));
  endtask
  task automatic t_flags();
    driver_fault_a = 1'b1;
    tk(3);
    chk("status_irq", 8'h01, 8'(status_irq));
    rd(8'h0C, 8'h09);
    rd(8'h0C, 8'h01);
    driver_fault_a = 1'b0;
    supply_autoretry_a = 1'b1;
    supply_overcurrent_a = 1'b1;
    tk(8);
    rd(8'h0C, 8'h24);
    supply_autoretry_a = 1'b0;
    supply_overcurrent_a = 1'b0;
    pls(supply_fall_a);
    tk(3);
    rd(8'h0C, 8'h12);
    pls(supply_rise_a);
    tk(2);
    rd(8'h0C, 8'h00);
  endtask
  task automatic t_tx();
    u_host.wr(8'h0B, 8'h90);
    tx_load_valid_b = 1'b1;
    tk(2);
    tx_load_valid_b = 1'b0;
    pls(tx_msg_loaded_b);
    chk("tx err", 8'h01, 8'(tx_error_irq_b));
    chk("q reset", 8'h01, 8'(tx_queue_reset_b));
    pls(tx_send_start_b);
    pls(tx_load_valid_b);
    pls(tx_msg_loaded_b);
    chk("q reset", 8'h00, 8'(tx_queue_reset_b));
    pls(tx_send_done_b);
    chk("q reset", 8'h01, 8'(tx_queue_reset_b));
    u_host.wr(8'h0B, 8'h08);
    pls(tx_send_done_b);
    chk("q reset", 8'h00, 8'(tx_queue_reset_b));
    pls(transmit_queue_clear_b);
    chk("q reset", 8'h01, 8'(tx_queue_reset_b));
  endtask
  task automatic t_rx();
    u_host.wr(8'h0B, 8'h00);
    pls(rx_word_valid_b);
    chk("ready", 8'h01, 8'(rx_data_ready_irq_b));
    u_host.wr(8'h0B, 8'h02);
    rx_word_last_b = 1'b1;
    rx_frame_bad_b = 1'b1;
    pls(rx_word_valid_b);
    tk(1);
    chk("ready", 8'h00, 8'(rx_data_ready_irq_b));
    pls(line_error_read_b);
  endtask
  task automatic t_soft();
    u_host.wr(8'h0C, 8'h40);
    chk("framer", 8'h01, 8'(framer_enable_a));
    u_host.wr(8'h0C, 8'hC0);
    chk("soft", 8'h01, 8'(queue_reset_a));
    chk("framer", 8'h01, 8'(framer_enable_a));
    tk(1);
    chk("framer", 8'h00, 8'(framer_enable_a));
    chk("rx_pin_a", 8'h01, 8'(rx_pin_a));
    rd(8'h0C, 8'h00);
    rd(8'h0B, 8'h02);
  endtask
  initial begin
    {tx_load_valid_b, tx_msg_loaded_b, tx_send_start_b, tx_send_done_b} = 4'h0;
    {transmit_queue_clear_b, line_error_read_b, rx_word_valid_b, rx_word_last_b} = 4'h0;
    {rx_frame_bad_b, line_pin_b, tx_pin_b, framer_tx_a, framer_txen_a} = 5'h00;
    {tx_pin_a, tx_drive_enable_pin_a, line_rx_a, supply_fall_a, supply_rise_a} = 5'h00;
    {supply_overcurrent_a, supply_autoretry_a, driver_fault_a} = 3'h0;
    tx_load_data_b = 8'h3C;
    tx_length_field = 8'h03;
    rx_word_data_b = 8'h5A;
    blanking_cycles_a = 16'h0003;
    srst = 1'b1;
    tk(16);
    srst = 1'b0;
    t_regs();
    t_pol();
    t_flags();
    t_tx();
    t_rx();
    t_soft();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    summarize();
  end
endmodule
